// file: aac_consts.svh
// register offsets, field positions, reset values and sizes of the acquisition control block
`ifndef AAC_CONSTS_SVH
`define AAC_CONSTS_SVH
`define AAC_OFS_DATA     8'h00
`define AAC_OFS_CHAN     8'h04
`define AAC_OFS_RANGE    8'h08
`define AAC_OFS_STATUS   8'h0C
`define AAC_OFS_MODE     8'h10
`define AAC_OFS_INTCTL   8'h14
`define AAC_OFS_READBACK 8'h18
`define AAC_OFS_FIFO_RST 8'h1C
`define AAC_OFS_SOFT     8'h20
`define AAC_OFS_TMR0     8'h24
`define AAC_OFS_IRQ_CLR  8'h30
`define AAC_OFS_IRQ_STS  8'h34
`define AAC_MODE_FIFO    0
`define AAC_MODE_PACER   1
`define AAC_MODE_SOFT    2
`define AAC_MODE_SCAN    3
`define AAC_SEL_OFF      2'h0
`define AAC_SEL_A        2'h1
`define AAC_SEL_B        2'h2
`define AAC_GAIN_RST     2'h0
`define AAC_MODE_RST     4'h0
`define AAC_INTCTL_RST   4'h0
`define AAC_CHAN_RST     5'h00
`define AAC_TMR_RST      16'h0000
`define AAC_FIFO_AW      10
`define AAC_FIFO_DEPTH   11'h400
`define AAC_FIFO_HALF    11'h200
`endif

// file: aac_pkg.sv
// types shared by the acquisition control block
package aac_pkg;
	typedef enum logic {aac_idle, aac_wait} aac_conv_state_t;
endpackage : aac_pkg

// file: aac_timer.sv
// one timer channel: byte-wise loaded reload value, down counter and tick
`timescale 1ns/1ns
`include "aac_consts.svh"
module aac_timer (
	input  wire logic        i_core_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_wr,
	input  wire logic [7:0]  i_wbyte,
	input  wire logic        i_step,
	output logic      [15:0] o_count,
	output logic             o_tick,
	output logic             o_zero
);
	logic [15:0] reload;
	logic [7:0]  low_byte;
	logic        hi_next;

	assign o_zero = (reload == `AAC_TMR_RST);

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			reload   <= `AAC_TMR_RST;
			o_count  <= `AAC_TMR_RST;
			low_byte <= 8'h00;
			hi_next  <= 1'b0;
			o_tick   <= 1'b0;
		end else if (i_wr) begin
			// low byte first, the high byte commits the whole value [RULE14]
			if (!hi_next) begin
				low_byte <= i_wbyte;
			end else begin
				reload  <= {i_wbyte, low_byte};
				o_count <= {i_wbyte, low_byte};
			end
			hi_next <= !hi_next;
			o_tick  <= 1'b0;
		end else if (i_step && !o_zero) begin
			// a zero reload stops the channel [RULE17]
			if (o_count <= 16'h0001) begin
				o_count <= reload;
				o_tick  <= 1'b1;
			end else begin
				o_count <= o_count - 16'h0001;
				o_tick  <= 1'b0;
			end
		end else begin
			o_tick <= 1'b0;
		end
	end
endmodule : aac_timer

// file: aac_fifo.sv
// conversion result fifo held in flip-flops
`timescale 1ns/1ns
`include "aac_consts.svh"
module aac_fifo (
	input  wire logic        i_core_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_clear,
	input  wire logic        i_push,
	input  wire logic [20:0] i_wdata,
	input  wire logic        i_pop,
	output logic      [20:0] o_rdata,
	output logic             o_empty,
	output logic             o_half,
	output logic             o_full
);
	logic [20:0]               mem [0:`AAC_FIFO_DEPTH-1];
	logic [`AAC_FIFO_AW-1:0]   wr_ptr;
	logic [`AAC_FIFO_AW-1:0]   rd_ptr;
	logic [`AAC_FIFO_AW:0]     cnt;
	logic                      do_push;
	logic                      do_pop;

	// a push while full is dropped, the full flag stays up [RULE23]
	assign do_push = i_push && !o_full;
	assign do_pop  = i_pop && !o_empty;
	assign o_empty = (cnt == '0);
	assign o_half  = (cnt >= `AAC_FIFO_HALF);
	assign o_full  = (cnt == `AAC_FIFO_DEPTH);
	assign o_rdata = mem[rd_ptr];

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			cnt    <= '0;
		end else if (i_clear) begin
			// clear discards everything stored [RULE11]
			wr_ptr <= '0;
			rd_ptr <= '0;
			cnt    <= '0;
		end else begin
			if (do_push) begin
				wr_ptr <= wr_ptr + `AAC_FIFO_AW'(1'b1);
			end
			if (do_pop) begin
				rd_ptr <= rd_ptr + `AAC_FIFO_AW'(1'b1);
			end
			if (do_push && !do_pop) begin
				cnt <= cnt + (`AAC_FIFO_AW+1)'(1'b1);
			end else if (do_pop && !do_push) begin
				cnt <= cnt - (`AAC_FIFO_AW+1)'(1'b1);
			end
		end
	end

	// storage needs no reset; only written entries are ever popped
	always_ff @(posedge i_core_clk) begin
		if (do_push && !i_clear) begin
			mem[wr_ptr] <= i_wdata;
		end
	end
endmodule : aac_fifo

// file: aac_acq_ctrl.sv
// acquisition control top: ahb-lite registers, trigger and conversion sequencing, interrupt lines
//
// What this block does
// [RULE1] after reset the gain register holds the unity-gain code until written
// [RULE2] four gain codes, meaning x1/10/100/1000 or x1/2/4/8 by board variant
// [RULE3] reading the gain register returns the programmed gain code
// [RULE4] status register shows fifo empty, half-full and full
// [RULE5] full status rises when the fifo fills; later results may be lost
// [RULE6] busy status while a conversion runs and its result is stored
// [RULE7] mode setting combines fifo enable, pacer, software trigger and scan
// [RULE8] the mode register reads back its current setting
// [RULE9] the interrupt control register selects the active interrupt sources
// [RULE10] one read-back register returns mode and interrupt control together
// [RULE11] results go into a fifo; a fifo reset command discards all entries
// [RULE12] software should reset the fifo before starting a conversion run
// [RULE13] a software trigger makes one conversion pulse and stores the result
// [RULE14] three timer channels, index zero to two, loaded a byte at a time
// [RULE15] timer reads return the count in the low eight bits
// [RULE16] timer channels one and two cascade into the pacer trigger
// [RULE17] pacer stops when either pacer divider is zero
// [RULE18] software keeps the product of the two pacer dividers above twenty
// [RULE19] channel index 0..31; single channel or last channel of a scan
// [RULE20] first line source code: 0 off, 1 end of conversion, 2 fifo half-full
// [RULE21] second line source code: 0 off, 1 pacer timer, 2 external input
// [RULE22] a raised line holds until software clears it
// [RULE23] when full, new results are dropped and full stays until reset or drain
// [RULE24] with the fifo off each result goes into the data register and stays
`timescale 1ns/1ns
`include "aac_consts.svh"
module aac_acq_ctrl (
	input  wire logic        i_core_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	input  wire logic        i_conv_done,
	input  wire logic [15:0] i_conv_data,
	input  wire logic        i_ext_irq,
	output logic             o_hreadyout,
	output logic             o_hresp,
	output logic      [31:0] o_hrdata,
	output logic             o_conv_start,
	output logic      [4:0]  o_mux_channel,
	output logic      [1:0]  o_gain_code,
	output logic             o_first_interrupt_line,
	output logic             o_second_interrupt_line
);
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction : hit

	function automatic logic [7:0] tmr_ofs(input logic [1:0] idx);
		return `AAC_OFS_TMR0 + {4'h0, idx, 2'h0};
	endfunction : tmr_ofs

	logic                     ph_valid;
	logic                     ph_write;
	logic [7:0]               ph_addr;
	logic                     addr_take;
	logic                     wr;
	logic                     rd_do;
	logic [31:0]              read_word;
	logic [4:0]               chan_sel;
	logic [3:0]               mode;
	logic [3:0]               intctl;
	logic [20:0]              data_reg;
	logic [4:0]               scan_ch;
	aac_pkg::aac_conv_state_t st;
	logic                     soft_cmd;
	logic                     trig;
	logic                     done_ok;
	logic                     fifo_clear;
	logic                     fifo_pop;
	logic [20:0]              fifo_rdata;
	logic                     fifo_empty_flag;
	logic                     fifo_half_flag;
	logic                     fifo_overrun_flag;
	logic                     converter_busy_flag;
	logic [15:0]              tmr_count [0:2];
	logic [2:0]               tmr_tick;
	logic [2:0]               tmr_zero;
	logic [2:0]               tmr_wr;
	logic [2:0]               tmr_step;
	logic                     pacer_tick;
	logic                     half_q;
	logic                     ext_q;
	logic                     set1;
	logic                     set2;
	logic                     clr1;
	logic                     clr2;

	// bus slave: writes complete with no wait, reads take one wait state
	assign addr_take = i_hsel && i_hready && i_htrans[1];
	assign wr        = ph_valid && ph_write;
	assign rd_do     = ph_valid && !ph_write && !o_hreadyout;

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			ph_valid <= 1'b0;
			ph_write <= 1'b0;
			ph_addr  <= 8'h00;
		end else begin
			ph_valid <= addr_take;
			if (addr_take) begin
				ph_write <= i_hwrite;
				ph_addr  <= i_haddr[7:0];
			end
		end
	end

	// the wait state lets a write just before a read land first
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_hreadyout <= 1'b1;
			o_hresp     <= 1'b0;
			o_hrdata    <= 32'h0000_0000;
		end else begin
			o_hreadyout <= !(addr_take && !i_hwrite);
			o_hresp     <= 1'b0;
			if (rd_do) begin
				o_hrdata <= read_word;
			end
		end
	end

	always_comb begin
		read_word = 32'h0000_0000;
		if (hit(ph_addr, `AAC_OFS_DATA)) begin
			read_word = {11'h000, mode[`AAC_MODE_FIFO] ? fifo_rdata : data_reg};
		end else if (hit(ph_addr, `AAC_OFS_CHAN)) begin
			read_word = {27'h0000000, chan_sel};
		end else if (hit(ph_addr, `AAC_OFS_RANGE)) begin
			read_word = {30'h00000000, o_gain_code}; // [RULE3]
		end else if (hit(ph_addr, `AAC_OFS_STATUS)) begin
			read_word = {28'h0000000, converter_busy_flag, fifo_overrun_flag, fifo_half_flag, fifo_empty_flag}; // [RULE4]
		end else if (hit(ph_addr, `AAC_OFS_MODE)) begin
			read_word = {28'h0000000, mode}; // [RULE8]
		end else if (hit(ph_addr, `AAC_OFS_INTCTL)) begin
			read_word = {28'h0000000, intctl};
		end else if (hit(ph_addr, `AAC_OFS_READBACK)) begin
			read_word = {24'h000000, intctl, mode}; // [RULE10]
		end else if (hit(ph_addr, `AAC_OFS_IRQ_STS)) begin
			read_word = {30'h00000000, o_second_interrupt_line, o_first_interrupt_line};
		end else if (hit(ph_addr, tmr_ofs(2'h0))) begin
			read_word = {24'h000000, tmr_count[0][7:0]}; // [RULE15]
		end else if (hit(ph_addr, tmr_ofs(2'h1))) begin
			read_word = {24'h000000, tmr_count[1][7:0]}; // [RULE15]
		end else if (hit(ph_addr, tmr_ofs(2'h2))) begin
			read_word = {24'h000000, tmr_count[2][7:0]}; // [RULE15]
		end
	end

	// software-written configuration
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			o_gain_code <= `AAC_GAIN_RST; // [RULE1]
			chan_sel    <= `AAC_CHAN_RST;
			mode        <= `AAC_MODE_RST;
			intctl      <= `AAC_INTCTL_RST;
		end else if (wr) begin
			if (hit(ph_addr, `AAC_OFS_RANGE)) begin
				o_gain_code <= i_hwdata[1:0]; // [RULE2]
			end else if (hit(ph_addr, `AAC_OFS_CHAN)) begin
				chan_sel <= i_hwdata[4:0]; // [RULE19]
			end else if (hit(ph_addr, `AAC_OFS_MODE)) begin
				mode <= i_hwdata[3:0]; // [RULE7]
			end else if (hit(ph_addr, `AAC_OFS_INTCTL)) begin
				intctl <= i_hwdata[3:0]; // [RULE9]
			end
		end
	end

	// timers: channel 0 free running, 1 and 2 cascaded as the pacer
	assign tmr_step   = {tmr_tick[1], 1'b1, 1'b1}; // [RULE16]
	// gated so a divider zeroed in the tick cycle cannot leak one last trigger [RULE17]
	assign pacer_tick = tmr_tick[2] && !tmr_zero[1] && !tmr_zero[2];

	for (genvar g = 0; g < 3; g++) begin : g_tmr
		assign tmr_wr[g] = wr && hit(ph_addr, tmr_ofs(2'(g))); // [RULE14]
		aac_timer u_tmr (
			.i_core_clk (i_core_clk),
			.i_arst_n   (i_arst_n),
			.i_wr       (tmr_wr[g]),
			.i_wbyte    (i_hwdata[7:0]),
			.i_step     (tmr_step[g]),
			.o_count    (tmr_count[g]),
			.o_tick     (tmr_tick[g]),
			.o_zero     (tmr_zero[g])
		);
	end

	// conversion sequencing; triggers arriving while busy are ignored
	assign soft_cmd = wr && hit(ph_addr, `AAC_OFS_SOFT);
	assign trig     = (soft_cmd && mode[`AAC_MODE_SOFT]) || (pacer_tick && mode[`AAC_MODE_PACER]);
	assign done_ok  = (st == aac_pkg::aac_wait) && i_conv_done;
	assign converter_busy_flag = (st == aac_pkg::aac_wait); // [RULE6]

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st            <= aac_pkg::aac_idle;
			o_conv_start  <= 1'b0;
			o_mux_channel <= `AAC_CHAN_RST;
			scan_ch       <= `AAC_CHAN_RST;
		end else begin
			o_conv_start <= 1'b0;
			case (st)
				aac_pkg::aac_idle: begin
					if (trig) begin
						o_conv_start  <= 1'b1; // [RULE13]
						o_mux_channel <= mode[`AAC_MODE_SCAN] ? scan_ch : chan_sel; // [RULE19]
						st            <= aac_pkg::aac_wait;
					end
				end
				aac_pkg::aac_wait: begin
					if (i_conv_done) begin
						st <= aac_pkg::aac_idle;
						// single-channel conversions leave the scan position alone
						if (mode[`AAC_MODE_SCAN]) begin
							if (scan_ch >= chan_sel) begin
								scan_ch <= `AAC_CHAN_RST;
							end else begin
								scan_ch <= scan_ch + 5'h01;
							end
						end
					end
				end
				default: begin
					st <= aac_pkg::aac_idle;
				end
			endcase
			// a new mode restarts any scan at channel zero [RULE19]
			if (wr && hit(ph_addr, `AAC_OFS_MODE)) begin
				scan_ch <= `AAC_CHAN_RST;
			end
		end
	end

	// with the fifo off the data register keeps the last result
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			data_reg <= 21'h000000;
		end else if (done_ok && !mode[`AAC_MODE_FIFO]) begin
			data_reg <= {o_mux_channel, i_conv_data}; // [RULE24]
		end
	end

	assign fifo_clear = wr && hit(ph_addr, `AAC_OFS_FIFO_RST); // [RULE11]
	assign fifo_pop   = rd_do && hit(ph_addr, `AAC_OFS_DATA) && mode[`AAC_MODE_FIFO];

	aac_fifo u_fifo (
		.i_core_clk (i_core_clk),
		.i_arst_n   (i_arst_n),
		.i_clear    (fifo_clear),
		.i_push     (done_ok && mode[`AAC_MODE_FIFO]),
		.i_wdata    ({o_mux_channel, i_conv_data}),
		.i_pop      (fifo_pop),
		.o_rdata    (fifo_rdata),
		.o_empty    (fifo_empty_flag),
		.o_half     (fifo_half_flag),
		.o_full     (fifo_overrun_flag) // [RULE5]
	);

	// interrupt lines: a set in the clearing cycle wins
	assign set1 = (intctl[1:0] == `AAC_SEL_A && done_ok)
		|| (intctl[1:0] == `AAC_SEL_B && fifo_half_flag && !half_q); // [RULE20]
	assign set2 = (intctl[3:2] == `AAC_SEL_A && pacer_tick)
		|| (intctl[3:2] == `AAC_SEL_B && i_ext_irq && !ext_q); // [RULE21]
	assign clr1 = wr && hit(ph_addr, `AAC_OFS_IRQ_CLR) && i_hwdata[0];
	assign clr2 = wr && hit(ph_addr, `AAC_OFS_IRQ_CLR) && i_hwdata[1];

	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			half_q                  <= 1'b0;
			ext_q                   <= 1'b0;
			o_first_interrupt_line  <= 1'b0;
			o_second_interrupt_line <= 1'b0;
		end else begin
			half_q                  <= fifo_half_flag;
			ext_q                   <= i_ext_irq;
			o_first_interrupt_line  <= set1 || (o_first_interrupt_line && !clr1); // [RULE22]
			o_second_interrupt_line <= set2 || (o_second_interrupt_line && !clr2); // [RULE22]
		end
	end

	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);

	gain_hold_a: assert property (!(wr && hit(ph_addr, `AAC_OFS_RANGE)) |=> $stable(o_gain_code)) // [RULE1]
		else $error("gain code changed without a write");
	gain_readback_a: assert property ((wr && hit(ph_addr, `AAC_OFS_RANGE)) ##1 !wr ##1 // [RULE3]
		(rd_do && hit(ph_addr, `AAC_OFS_RANGE)) |=> o_hrdata[1:0] == $past(i_hwdata[1:0], 3))
		else $error("gain read-back differs from written code");
	status_read_a: assert property (rd_do && hit(ph_addr, `AAC_OFS_STATUS) // [RULE4]
		|=> o_hrdata[3:0] == $past({converter_busy_flag, fifo_overrun_flag, fifo_half_flag, fifo_empty_flag}))
		else $error("status read-back wrong");
	busy_span_a: assert property ((o_conv_start |-> converter_busy_flag) // [RULE6]
		and (converter_busy_flag && !done_ok |=> converter_busy_flag))
		else $error("busy dropped before the result was stored");
	soft_pulse_a: assert property (soft_cmd && mode[`AAC_MODE_SOFT] && !converter_busy_flag // [RULE13]
		|=> o_conv_start ##1 !o_conv_start)
		else $error("software trigger gave no single pulse");
	pacer_stop_a: assert property ((tmr_zero[1] || tmr_zero[2]) && !soft_cmd |=> !o_conv_start) // [RULE17]
		else $error("conversion started with a zero pacer divider");
	fifo_clear_a: assert property (fifo_clear |=> fifo_empty_flag && !fifo_half_flag) // [RULE11]
		else $error("fifo not empty after reset command");
	full_hold_a: assert property (fifo_overrun_flag && !fifo_pop && !fifo_clear |=> fifo_overrun_flag) // [RULE23]
		else $error("full flag dropped without drain or reset");
	irq_hold_a: assert property (o_first_interrupt_line && !clr1 |=> o_first_interrupt_line) // [RULE22]
		else $error("first line dropped without clear");
	eoc_irq_a: assert property (intctl[1:0] == `AAC_SEL_A && done_ok |=> o_first_interrupt_line) // [RULE20]
		else $error("end of conversion raised no interrupt");
	direct_data_a: assert property (done_ok && !mode[`AAC_MODE_FIFO] // [RULE24]
		|=> data_reg[15:0] == $past(i_conv_data))
		else $error("result not in data register");
	pacer_cascade_a: assert property (pacer_tick |-> $past(tmr_tick[1])) // [RULE16]
		else $error("pacer tick without a channel one tick");

	soft_conv_c: cover property (soft_cmd ##[1:20] done_ok);
	fifo_full_c: cover property (fifo_overrun_flag);
	pacer_conv_c: cover property (pacer_tick && mode[`AAC_MODE_PACER] ##[1:20] done_ok);
	ext_irq_c: cover property (o_second_interrupt_line ##1 clr2);
endmodule : aac_acq_ctrl

// file: aac_conv_model.sv
// converter partner model: answers each conversion start with one result strobe after a set delay
`timescale 1ns/1ns
module aac_conv_model (
	input  wire logic        i_core_clk,
	input  wire logic        i_arst_n,
	input  wire logic        i_conv_start,
	input  wire logic [3:0]  i_delay,
	output logic             o_conv_done,
	output logic      [15:0] o_conv_data
);
	logic        pend;
	logic [3:0]  wait_cnt;
	logic [15:0] count;
	// data flips every cycle outside the strobe so a stale result can never pass as fresh
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pend        <= 1'b0;
			wait_cnt    <= 4'h0;
			count       <= 16'h0000;
			o_conv_done <= 1'b0;
			o_conv_data <= 16'h0000;
		end else begin
			o_conv_done <= 1'b0;
			o_conv_data <= ~o_conv_data;
			if (i_conv_start) begin
				pend     <= 1'b1;
				wait_cnt <= i_delay;
			end else if (pend && wait_cnt <= 4'h1) begin
				pend        <= 1'b0;
				o_conv_done <= 1'b1;
				o_conv_data <= 16'hA000 + count;
				count       <= count + 16'h0001;
			end else if (pend) begin
				wait_cnt <= wait_cnt - 4'h1;
			end
		end
	end
endmodule : aac_conv_model

// file: adc_acquisition_control_tb.sv
// self-checking bench for the acquisition control block with a converter model on the far side
`timescale 1ns/1ns
`include "aac_consts.svh"
module adc_acquisition_control_tb;
	logic        clk;
	logic        rst_n;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic        hresp;
	logic [31:0] hrdata;
	logic        conv_start;
	logic        conv_done;
	logic [15:0] conv_data;
	logic        ext_irq;
	logic [3:0]  delay;
	logic [4:0]  mux_ch;
	logic [1:0]  gain;
	logic        line1;
	logic        line2;
	logic [31:0] rd;
	int          miscompares;
	int          comparisons;
	int          nconv;
	int          base;

	aac_acq_ctrl dut (.i_core_clk(clk), .i_arst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hreadyout), .i_conv_done(conv_done),
		.i_conv_data(conv_data), .i_ext_irq(ext_irq), .o_hreadyout(hreadyout), .o_hresp(hresp), .o_hrdata(hrdata),
		.o_conv_start(conv_start), .o_mux_channel(mux_ch), .o_gain_code(gain),
		.o_first_interrupt_line(line1), .o_second_interrupt_line(line2));
	aac_conv_model conv (.i_core_clk(clk), .i_arst_n(rst_n), .i_conv_start(conv_start), .i_delay(delay),
		.o_conv_done(conv_done), .o_conv_data(conv_data));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic tally_and_finish;
		$display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	// the master never assumes a wait count; only the cap guards a dead bus
	task automatic wait_rdy;
		int n;
		n = 0;
		@(posedge clk);
		while (hreadyout !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		if (hreadyout !== 1'b1) begin
			miscompares++;
			$display("MISMATCH t=%0t hready got=%h exp=%h", $time, hreadyout, 1'b1);
		end
	endtask : wait_rdy

	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel   <= 1'b1;
		haddr  <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask : bus

	task automatic chk_reg(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask : chk_reg

	// pins are looked at mid-cycle, then the bench steps back onto a rising edge
	task automatic chk_pins(input logic [4:0] ch, input logic [1:0] g, input logic e1, input logic e2);
		@(negedge clk);
		chk({23'h0, mux_ch, gain, line1, line2}, {23'h0, ch, g, e1, e2});
		@(posedge clk);
	endtask : chk_pins

	task automatic wait_done;
		int n;
		n = 0;
		while (conv_done !== 1'b1 && n < 100) begin
			@(posedge clk);
			n++;
		end
		if (conv_done !== 1'b1) begin
			miscompares++;
			$display("MISMATCH t=%0t conv_done got=%h exp=%h", $time, conv_done, 1'b1);
		end
		@(posedge clk);
		nconv++;
	endtask : wait_done

	task automatic soft_conv;
		bus(1'b1, `AAC_OFS_SOFT, 32'h1);
		wait_done();
	endtask : soft_conv

	function automatic logic [31:0] word(input logic [4:0] ch, input int k);
		return {11'h0, ch, 16'hA000 + k[15:0]};
	endfunction : word

	initial begin
		repeat (40000) @(posedge clk);
		miscompares++;
		tally_and_finish();
	end

	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		ext_irq = 1'b0;
		delay = 4'h1;
		miscompares = 0;
		comparisons = 0;
		nconv = 0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk_pins(5'h00, 2'h0, 1'b0, 1'b0);
		chk_reg(`AAC_OFS_RANGE, 32'h0);
		chk_reg(`AAC_OFS_STATUS, 32'h1);
		chk_reg(`AAC_OFS_READBACK, 32'h0);
		chk_reg(8'h3C, 32'h0);
		$display("reset values done");
		for (int g = 3; g >= 0; g--) begin
			bus(1'b1, `AAC_OFS_RANGE, {30'h3FFFFFFF, 2'(g)});
			chk_reg(`AAC_OFS_RANGE, 32'(g));
			chk_pins(5'h00, 2'(g), 1'b0, 1'b0);
		end
		$display("gain done");
		for (int m = 0; m < 16; m++) begin
			bus(1'b1, `AAC_OFS_MODE, 32'(m));
			bus(1'b1, `AAC_OFS_INTCTL, {28'h0, 2'(m % 3), 2'((m + 1) % 3)});
			chk_reg(`AAC_OFS_MODE, 32'(m));
			chk_reg(`AAC_OFS_READBACK, {24'h0, 2'(m % 3), 2'((m + 1) % 3), 4'(m)});
		end
		$display("mode done");
		bus(1'b1, `AAC_OFS_CHAN, 32'h5);
		bus(1'b1, `AAC_OFS_MODE, 32'h4);
		bus(1'b1, `AAC_OFS_INTCTL, 32'h1);
		delay <= 4'hF;
		bus(1'b1, `AAC_OFS_SOFT, 32'h1);
		chk_reg(`AAC_OFS_STATUS, 32'h9);
		wait_done();
		delay <= 4'h1;
		chk_reg(`AAC_OFS_DATA, word(5'h05, nconv - 1));
		chk_reg(`AAC_OFS_STATUS, 32'h1);
		chk_pins(5'h05, 2'h0, 1'b1, 1'b0);
		soft_conv();
		chk_reg(`AAC_OFS_DATA, word(5'h05, nconv - 1));
		chk_reg(`AAC_OFS_DATA, word(5'h05, nconv - 1));
		chk_reg(`AAC_OFS_IRQ_STS, 32'h1);
		bus(1'b1, `AAC_OFS_IRQ_CLR, 32'h1);
		chk_pins(5'h05, 2'h0, 1'b0, 1'b0);
		$display("direct conversion done");
		bus(1'b1, `AAC_OFS_MODE, 32'h5);
		bus(1'b1, `AAC_OFS_INTCTL, 32'h2);
		bus(1'b1, `AAC_OFS_FIFO_RST, 32'h1);
		base = nconv;
		for (int i = 0; i < 1025; i++) begin
			soft_conv();
			if (i == 510) chk_reg(`AAC_OFS_STATUS, 32'h0);
			if (i == 511) chk_reg(`AAC_OFS_STATUS, 32'h2);
		end
		chk_pins(5'h05, 2'h0, 1'b1, 1'b0);
		chk_reg(`AAC_OFS_STATUS, 32'h6);
		chk_reg(`AAC_OFS_DATA, word(5'h05, base));
		chk_reg(`AAC_OFS_DATA, word(5'h05, base + 1));
		chk_reg(`AAC_OFS_STATUS, 32'h2);
		bus(1'b1, `AAC_OFS_FIFO_RST, 32'h1);
		chk_reg(`AAC_OFS_STATUS, 32'h1);
		bus(1'b1, `AAC_OFS_IRQ_CLR, 32'h3);
		$display("fifo done");
		bus(1'b1, `AAC_OFS_CHAN, 32'h2);
		bus(1'b1, `AAC_OFS_MODE, 32'hC);
		for (int i = 0; i < 4; i++) begin
			soft_conv();
			chk_pins(5'(i % 3), 2'h0, 1'b0, 1'b0);
		end
		$display("scan done");
		bus(1'b1, `AAC_OFS_INTCTL, 32'h8);
		ext_irq <= 1'b1;
		repeat (3) @(posedge clk);
		chk_reg(`AAC_OFS_IRQ_STS, 32'h2);
		ext_irq <= 1'b0;
		bus(1'b1, `AAC_OFS_IRQ_CLR, 32'h2);
		chk_reg(`AAC_OFS_IRQ_STS, 32'h0);
		$display("external line done");
		bus(1'b1, `AAC_OFS_INTCTL, 32'h4);
		bus(1'b1, `AAC_OFS_FIFO_RST, 32'h1);
		bus(1'b1, `AAC_OFS_TMR0 + 8'h04, 32'h3);
		bus(1'b1, `AAC_OFS_TMR0 + 8'h04, 32'h0);
		bus(1'b1, `AAC_OFS_TMR0 + 8'h08, 32'h8);
		bus(1'b1, `AAC_OFS_TMR0 + 8'h08, 32'h0);
		bus(1'b0, `AAC_OFS_TMR0 + 8'h04, 32'h0);
		chk(32'(rd[7:0] >= 8'h01 && rd[7:0] <= 8'h03), 32'h1);
		bus(1'b1, `AAC_OFS_MODE, 32'h3);
		repeat (240) @(posedge clk);
		chk_reg(`AAC_OFS_IRQ_STS, 32'h2);
		bus(1'b0, `AAC_OFS_STATUS, 32'h0);
		chk({31'h0, rd[0]}, 32'h0);
		bus(1'b1, `AAC_OFS_TMR0 + 8'h08, 32'h0);
		bus(1'b1, `AAC_OFS_TMR0 + 8'h08, 32'h0);
		repeat (20) @(posedge clk);
		bus(1'b1, `AAC_OFS_FIFO_RST, 32'h1);
		bus(1'b1, `AAC_OFS_IRQ_CLR, 32'h2);
		repeat (200) @(posedge clk);
		chk_reg(`AAC_OFS_STATUS, 32'h1);
		chk_reg(`AAC_OFS_IRQ_STS, 32'h0);
		$display("pacer done");
		tally_and_finish();
	end
endmodule : adc_acquisition_control_tb
